/* ssc_pkg.sv */
/*
 * Shared constants and carrier types for the supply switch control block.
 * Assumes a 100 MHz reference clock and a classic Wishbone register bus.
 */
package ssc_pkg;

	// ------------------------------------------------------------
	// Register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL0 = 8'h00;
	localparam logic [7:0] OFS_CTRL1 = 8'h04;
	localparam logic [7:0] OFS_CTRL2 = 8'h08;
	localparam logic [7:0] OFS_STAT = 8'h0C;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int POS_LOCK = 0;
	localparam int POS_KEY = 8;
	localparam int POS_MODE = 0;
	localparam int POS_VALID = 4;
	localparam int POS_PRIO = 8;
	localparam int POS_MONEN = 0;
	localparam int POS_ACTIVE = 0;
	localparam int POS_SLOCK = 4;
	localparam int POS_RECOV = 5;
	localparam int POS_SVALID = 8;
	localparam int POS_BACKUP = 12;
	localparam int POS_EVENT = 16;

	// ------------------------------------------------------------
	// Values and reset values
	// ------------------------------------------------------------
	localparam logic [7:0] UNLOCK_KEY = 8'hA5;
	localparam logic [2:0] SUP_NONE = 3'h0;
	localparam logic [2:0] SUP_PRI = 3'h1;
	localparam logic [2:0] SUP_ALT1 = 3'h2;
	localparam logic [2:0] SUP_ALT2 = 3'h4;
	localparam logic [2:0] ALL_SW = 3'h7;
	localparam logic RST_LOCK = 1'b1;
	localparam logic [7:0] RST_KEY = 8'h00;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int RECOVERY_TIME_US = 300;
	localparam int RECOVERY_CYCLES =
		(RECOVERY_TIME_US * 1000) / CLK_PERIOD_NS;

	// ------------------------------------------------------------
	// Wishbone carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} ssc_wb_req_t;

	typedef struct packed {
		logic ack;
		logic [31:0] dat;
	} ssc_wb_rsp_t;

endpackage

/* ssc_supply_switch_control.sv */
/*
 * Supply switch control: picks which input supply feeds both system rails,
 * with start-up choice, key-protected lock, software and monitor driven
 * switching, priority and a recovery hold-off.
 * Assumes all inputs synchronous to ref_clk and a classic Wishbone master.
 */
`timescale 1ns/1ps
module ssc_supply_switch_control #(
	parameter int RECOVERY_CNT = ssc_pkg::RECOVERY_CYCLES
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Register bus
	input wire ssc_pkg::ssc_wb_req_t wbReq,
	output ssc_pkg::ssc_wb_rsp_t wbRsp,
	// Supply sensing
	input wire logic primaryIsHigher,
	input wire logic [2:0] thresholdOk,
	input wire logic monitorTrigger,
	input wire logic supervisorEnable,
	// Rail switches and status
	output logic [2:0] digitalRailSel,
	output logic [2:0] analogRailSel,
	output logic switchEvent,
	output logic backupAccessOk
);
	import ssc_pkg::*;

	// ------------------------------------------------------------
	// Parameter check
	// ------------------------------------------------------------
	if (RECOVERY_CNT < 1 || RECOVERY_CNT > 65535) begin : g_chk
		$error("RECOVERY_CNT out of range");
	end

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic started;
		logic lock;
		logic [7:0] key;
		logic [2:0] mode;
		logic [2:0] swValid;
		logic prio;
		logic monEn;
		logic [2:0] active;
		logic [2:0] validPrev;
		logic [15:0] recCnt;
		logic [2:0] evt;
		logic pulse;
		logic backup;
		ssc_wb_rsp_t rsp;
	} ssc_state_t;

	ssc_state_t st_ff;
	ssc_state_t nxt_st;
	logic [2:0] validNow;
	logic [2:0] rise;
	logic [2:0] cand;
	logic access;
	logic wrStrobe;
	logic rdStrobe;

	// Highest priority supply among the given valid set
	function automatic logic [2:0] bestSupply(
		input logic [2:0] v,
		input logic p
	);
		logic [2:0] r;
		r = SUP_NONE;
		if (v[0]) begin
			r = SUP_PRI;
		end else if (p && v[2]) begin
			r = SUP_ALT2;
		end else if (v[1]) begin
			r = SUP_ALT1;
		end else if (v[2]) begin
			r = SUP_ALT2;
		end
		return r;
	endfunction

	// Byte-lane merge for writes
	function automatic logic [31:0] laneMerge(
		input logic [31:0] old,
		input logic [31:0] wd,
		input logic [3:0] sel
	);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// ------------------------------------------------------------
	// Decode helpers
	// ------------------------------------------------------------
	assign validNow = (st_ff.mode & st_ff.swValid)
		| (~st_ff.mode & thresholdOk);
	assign rise = validNow & ~st_ff.validPrev;
	assign access = !st_ff.lock && st_ff.key == UNLOCK_KEY;
	assign wrStrobe = wbReq.cyc && wbReq.stb && wbReq.we && !st_ff.rsp.ack;
	assign rdStrobe = wbReq.cyc && wbReq.stb && !wbReq.we && !st_ff.rsp.ack;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		logic [31:0] w;
		logic newLock;
		w = 32'h0;
		newLock = 1'b0;
		nxt_st = st_ff;
		nxt_st.started = 1'b1;
		nxt_st.pulse = 1'b0;
		nxt_st.validPrev = validNow;
		nxt_st.backup = supervisorEnable;
		nxt_st.rsp.ack = wbReq.cyc && wbReq.stb && !st_ff.rsp.ack;
		if (st_ff.recCnt != 16'h0) begin
			nxt_st.recCnt = st_ff.recCnt - 16'h1;
		end
		cand = SUP_NONE;

		// Start-up choice, taken at the first edge after reset
		if (!st_ff.started) begin
			nxt_st.active = primaryIsHigher ? SUP_PRI : SUP_ALT1;
		end else if (!st_ff.lock && st_ff.recCnt == 16'h0) begin
			// Switch causes in order of precedence
			if (st_ff.active != SUP_PRI && rise[0]) begin
				cand = SUP_PRI;
			end else if (|(rise & st_ff.mode)) begin
				cand = bestSupply(validNow, st_ff.prio);
			end else if (|(st_ff.active & st_ff.mode
					& st_ff.validPrev & ~validNow)) begin
				cand = bestSupply(validNow & ~st_ff.active,
					st_ff.prio);
			end else if (monitorTrigger && st_ff.monEn
					&& st_ff.mode != ALL_SW) begin
				cand = bestSupply(validNow & ~st_ff.active,
					st_ff.prio);
			end
			if (cand != SUP_NONE && cand != st_ff.active) begin
				nxt_st.active = cand;
				nxt_st.recCnt = 16'(RECOVERY_CNT);
				nxt_st.pulse = 1'b1;
			end
		end

		// Register writes
		if (wrStrobe) begin
			unique case (wbReq.adr)
				OFS_CTRL0: begin
					w = laneMerge({16'h0, st_ff.key, 7'h0, st_ff.lock},
						wbReq.dat, wbReq.sel);
					newLock = w[POS_LOCK];
					nxt_st.lock = newLock;
					if (!newLock) begin
						nxt_st.key = w[POS_KEY +: 8];
					end
				end
				OFS_CTRL1: begin
					if (access) begin
						w = laneMerge({23'h0, st_ff.prio, 1'b0,
							st_ff.swValid, 1'b0, st_ff.mode},
							wbReq.dat, wbReq.sel);
						nxt_st.mode = w[POS_MODE +: 3];
						nxt_st.swValid = w[POS_VALID +: 3];
						nxt_st.prio = w[POS_PRIO];
					end
				end
				OFS_CTRL2: begin
					if (access && wbReq.sel[0]) begin
						nxt_st.monEn = wbReq.dat[POS_MONEN];
					end
				end
				OFS_STAT: begin
					if (wbReq.sel[2]) begin
						nxt_st.evt = st_ff.evt
							& ~wbReq.dat[POS_EVENT +: 3];
					end
				end
				default: begin
				end
			endcase
		end

		// Sticky switch events, set wins over clear
		if (nxt_st.pulse) begin
			nxt_st.evt = nxt_st.evt | nxt_st.active;
		end

		// Register reads
		if (rdStrobe) begin
			unique case (wbReq.adr)
				OFS_CTRL0: nxt_st.rsp.dat =
					{16'h0, st_ff.key, 7'h0, st_ff.lock};
				OFS_CTRL1: nxt_st.rsp.dat = {23'h0, st_ff.prio, 1'b0,
					st_ff.swValid, 1'b0, st_ff.mode};
				OFS_CTRL2: nxt_st.rsp.dat = {31'h0, st_ff.monEn};
				OFS_STAT: nxt_st.rsp.dat = {13'h0, st_ff.evt, 3'h0,
					st_ff.backup, 1'b0, validNow, 2'h0,
					st_ff.recCnt != 16'h0, st_ff.lock, 1'b0,
					st_ff.active};
				default: nxt_st.rsp.dat = 32'h0;
			endcase
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= '0;
			st_ff.lock <= RST_LOCK;
			st_ff.key <= RST_KEY;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Outputs straight from the state
	assign digitalRailSel = st_ff.active;
	assign analogRailSel = st_ff.active;
	assign switchEvent = st_ff.pulse;
	assign backupAccessOk = st_ff.backup;
	assign wbRsp = st_ff.rsp;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	AST_RAILS_MATCH: assert property (
		digitalRailSel == analogRailSel && $onehot0(digitalRailSel))
		else $error("rail selects differ");

	AST_STARTUP: assert property (
		$rose(st_ff.started) |-> st_ff.active ==
			($past(primaryIsHigher) ? SUP_PRI : SUP_ALT1))
		else $error("start-up supply wrong");

	AST_LOCK_HOLD: assert property (
		st_ff.started && st_ff.lock |=> $stable(st_ff.active))
		else $error("switch while locked");

	AST_LOCKED_CFG: assert property (
		wrStrobe && wbReq.adr == OFS_CTRL1 && !access
			|=> $stable(st_ff.mode) && $stable(st_ff.prio))
		else $error("locked config changed");

	AST_KEY_LOCKED: assert property (
		wrStrobe && wbReq.adr == OFS_CTRL0 && wbReq.sel[0]
			&& wbReq.dat[POS_LOCK] |=> $stable(st_ff.key))
		else $error("key written while locked");

	AST_RECOVERY: assert property (
		$past(st_ff.pulse) |-> $stable(st_ff.active) [*8])
		else $error("switch during recovery");

	AST_EVENT: assert property (
		st_ff.started && $past(st_ff.started)
			&& st_ff.active != $past(st_ff.active)
			|-> switchEvent && (st_ff.evt & st_ff.active) != 3'h0)
		else $error("switch without event");

	AST_BACKUP: assert property (
		!supervisorEnable |=> !backupAccessOk)
		else $error("backup open while supervisor off");

endmodule // ssc_supply_switch_control

/* ssc_monitor_model.sv */
/*
 * Supply monitor stand-in: delayed trigger pulse and threshold levels.
 * Assumes bench commands change just after rising edges of ref_clk.
 */
`timescale 1ns/1ps
module ssc_monitor_model (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Bench commands
	input wire logic fireReq,
	input wire logic [3:0] fireDelay,
	input wire logic [2:0] levelOk,
	// Monitor outputs
	output logic monitorTrigger,
	output logic [2:0] thresholdOk
);
	logic [4:0] cnt_ff;

	// Trigger after a chosen delay, levels one cycle late
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff <= 5'h00;
			monitorTrigger <= 1'h0;
			thresholdOk <= 3'h0;
		end else begin
			thresholdOk <= levelOk;
			monitorTrigger <= (cnt_ff == 5'h01);
			if (fireReq)
				cnt_ff <= {1'h0, fireDelay} + 5'h01;
			else if (cnt_ff != 5'h00)
				cnt_ff <= cnt_ff - 5'h01;
		end
	end
endmodule // ssc_monitor_model

/* ssc_supply_switch_control_bench.sv */
/*
 * Self-checking bench for the supply switch control with a reference model.
 * Assumes ssc_pkg and the monitor model are compiled first.
 */
`timescale 1ns/1ps
module ssc_supply_switch_control_bench;
	import ssc_pkg::*;
	localparam int RECOV = 20;
	logic ref_clk = 1'h0;
	logic rst_n;
	ssc_wb_req_t wbReq;
	ssc_wb_rsp_t wbRsp;
	logic primaryIsHigher;
	logic supervisorEnable;
	logic monitorTrigger;
	logic switchEvent;
	logic backupAccessOk;
	logic fireReq;
	logic quick;
	logic prio;
	logic monEn;
	logic [3:0] fireDelay;
	logic [2:0] thresholdOk;
	logic [2:0] levelOk;
	logic [2:0] digitalRailSel;
	logic [2:0] analogRailSel;
	logic [2:0] act;
	logic [2:0] effV;
	logic [2:0] mode;
	logic [31:0] rd;
	logic [2:0] expEvt;
	logic [31:0] swSeq [6] = '{32'h27, 32'h167, 32'h127, 32'h137, 32'h7,
		32'h17};
	int seed = 32'h3765;
	int fail_count = 0;
	int cmp_count = 0;
	int evCnt = 0;
	int expEv = 0;

	ssc_supply_switch_control #(.RECOVERY_CNT(RECOV)) dut (
		.ref_clk(ref_clk), .rst_n(rst_n), .wbReq(wbReq), .wbRsp(wbRsp),
		.primaryIsHigher(primaryIsHigher), .thresholdOk(thresholdOk),
		.monitorTrigger(monitorTrigger), .supervisorEnable(supervisorEnable),
		.digitalRailSel(digitalRailSel), .analogRailSel(analogRailSel),
		.switchEvent(switchEvent), .backupAccessOk(backupAccessOk));
	ssc_monitor_model mon (
		.ref_clk(ref_clk), .rst_n(rst_n), .fireReq(fireReq),
		.fireDelay(fireDelay), .levelOk(levelOk),
		.monitorTrigger(monitorTrigger), .thresholdOk(thresholdOk));

	// ----
	// Clock, event counter, checks
	// ----
	always #5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) if (switchEvent === 1'h1) evCnt++;

	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("Error t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task chkRail;
		cmp_count++;
		if (digitalRailSel !== act || analogRailSel !== act || evCnt != expEv) begin
			fail_count++;
			$display("Error t=%0t got %h exp %h", $time,
				{digitalRailSel, analogRailSel, evCnt[7:0]}, {act, act, expEv[7:0]});
		end
	endtask

	task report_and_stop;
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Classic single cycle, waits for ack
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		wbReq <= '{1'h1, 1'h1, w, a, 4'hF, d};
		do @(posedge ref_clk); while (wbRsp.ack !== 1'h1);
		rd = wbRsp.dat;
		wbReq.cyc <= 1'h0;
		wbReq.stb <= 1'h0;
		@(posedge ref_clk);
	endtask

	// ----
	// Reference model
	// ----
	function automatic logic [2:0] best(input logic [2:0] v, input logic [2:0] ex);
		logic [2:0] g;
		g = v & ~ex;
		if (g[0]) return SUP_PRI;
		if (prio && g[2]) return SUP_ALT2;
		if (g[1]) return SUP_ALT1;
		return g[2] ? SUP_ALT2 : SUP_NONE;
	endfunction

	task step(input logic [2:0] nv, input logic trig);
		logic [2:0] nx;
		nx = SUP_NONE;
		if (nv[0] && !effV[0] && act != SUP_PRI) nx = SUP_PRI;
		else if ((nv & ~effV & mode) != 3'h0) nx = best(nv, 3'h0);
		else if ((act & mode & ~nv) != 3'h0) nx = best(nv, act);
		else if (trig && monEn && mode != ALL_SW) nx = best(nv, act);
		effV = nv;
		if (nx != SUP_NONE && nx != act) begin
			act = nx;
			expEvt = expEvt | act;
			expEv++;
		end
		repeat (4) @(posedge ref_clk);
		chkRail();
		if (!quick) repeat (RECOV + 2) @(posedge ref_clk);
	endtask

	task ctl1(input logic [31:0] v);
		wb(1'h1, OFS_CTRL1, v);
		mode = v[2:0];
		prio = v[8];
		step((v[6:4] & mode) | (levelOk & ~mode), 1'h0);
	endtask

	task lvl(input logic [2:0] v);
		levelOk <= v;
		@(posedge ref_clk);
		step(v, 1'h0);
	endtask

	task fire;
		fireDelay <= 4'($random(seed) & 3);
		fireReq <= 1'h1;
		@(posedge ref_clk);
		fireReq <= 1'h0;
		repeat (5) @(posedge ref_clk);
	endtask

	initial begin
		#200000;
		fail_count++;
		report_and_stop();
	end

	initial begin
		rst_n = 1'h0;
		wbReq = '0;
		primaryIsHigher = 1'($random(seed));
		supervisorEnable = 1'h0;
		levelOk = 3'h0;
		fireReq = 1'h0;
		fireDelay = 4'h0;
		{quick, prio, monEn, mode, effV} = '0;
		expEvt = 3'h0;
		repeat (5) @(posedge ref_clk);
		rst_n <= 1'h1;
		act = primaryIsHigher ? SUP_PRI : SUP_ALT1;
		repeat (3) @(posedge ref_clk);
		chkRail();
		wb(1'h0, OFS_CTRL0, 32'h0);
		chk(rd, 32'h1);
		wb(1'h1, OFS_CTRL1, 32'h77);
		wb(1'h0, OFS_CTRL1, 32'h0);
		chk(rd, 32'h0);
		wb(1'h1, OFS_CTRL0, 32'h5A00);
		wb(1'h1, OFS_CTRL1, 32'h77);
		wb(1'h0, OFS_CTRL1, 32'h0);
		chk(rd, 32'h0);
		wb(1'h1, OFS_CTRL0, 32'hA500);
		wb(1'h0, OFS_CTRL0, 32'h0);
		chk(rd, 32'hA500);
		wb(1'h0, 8'h10, 32'h0);
		chk(rd, 32'h0);
		chkRail();
		$display("lock test done");
		foreach (swSeq[i])
			ctl1(swSeq[i]);
		$display("software test done");
		ctl1(32'h0);
		lvl(3'h6);
		wb(1'h1, OFS_CTRL2, 32'h1);
		monEn = 1'h1;
		quick = 1'h1;
		fire();
		step(effV, 1'h1);
		fire();
		step(effV, 1'h0);
		quick = 1'h0;
		repeat (RECOV) @(posedge ref_clk);
		lvl(3'h7);
		ctl1(32'h77);
		fire();
		step(effV, 1'h1);
		$display("monitor test done");
		wb(1'h0, OFS_STAT, 32'h0);
		chk(rd, {13'h0, expEvt, 5'h0, effV, 5'h0, act});
		wb(1'h1, OFS_STAT, 32'h70000);
		wb(1'h0, OFS_STAT, 32'h0);
		chk(rd, {16'h0, 5'h0, effV, 5'h0, act});
		wb(1'h1, OFS_CTRL0, 32'h1);
		wb(1'h0, OFS_CTRL0, 32'h0);
		chk(rd, 32'hA501);
		$display("status test done");
		repeat (8) begin
			supervisorEnable <= 1'($random(seed));
			repeat (2) @(posedge ref_clk);
			chk({31'h0, backupAccessOk}, {31'h0, supervisorEnable});
		end
		$display("backup test done");
		report_and_stop();
	end
endmodule // ssc_supply_switch_control_bench
